// File: hw/sfdc_pkg.sv
// Constants, timing counts and types of the single-phase fan drive control block.
// Functional notes
// - At startup drive square wave from Hall
// - Above 5 Hz use predicted commutation timing
// - Hall polarity picks low output and modulated output
// - Rotation pulse follows each phase switch
// - Commutate early by the lead angle setting
// - Current limit cuts high side until next period
// - Ignore current limit during 1.5 us blanking
// - Over-current past 2 us: outputs off 100 ms
// - Lock: 0.4 s drive, 4 s off, auto recovery
// - Lock flag released in lock; pulse still follows
// - Thermal shutdown holds both outputs off
// - Minimum duty code clamps speed code from below
// - Seven-bit speed and minimum codes set duty
// - PWM period is 400 oscillator cycles
// - Pulse and lock outputs are open drain
// - Below startup speed use fixed 50% duty
// - Startup phase change inserts 1 ms off
package sfdc_pkg;
    localparam int unsigned PCLK_HZ        = 20_000_000;
    localparam int unsigned OSC_HZ         = 10_000_000;
    localparam int unsigned OSC_DIV        = PCLK_HZ / OSC_HZ;
    localparam int unsigned OSC_KHZ        = OSC_HZ / 1000;
    localparam int unsigned OSC_MHZ        = OSC_HZ / 1_000_000;
    localparam int unsigned PWM_PERIOD     = 400;
    localparam int unsigned DUTY_START     = PWM_PERIOD / 2;
    localparam int unsigned T_BLANK_NS     = 1500;
    localparam int unsigned BLANK_CYC      = (T_BLANK_NS * OSC_MHZ + 999) / 1000;
    localparam int unsigned T_OCP_MASK_NS  = 2000;
    localparam int unsigned OCP_MASK_CYC   = (T_OCP_MASK_NS * OSC_MHZ + 999) / 1000;
    localparam int unsigned T_OCP_OFF_MS   = 100;
    localparam int unsigned OCP_OFF_CYC    = T_OCP_OFF_MS * OSC_KHZ;
    localparam int unsigned T_LOCK_ON_MS   = 400;
    localparam int unsigned LOCK_ON_CYC    = T_LOCK_ON_MS * OSC_KHZ;
    localparam int unsigned T_LOCK_OFF_MS  = 4000;
    localparam int unsigned LOCK_OFF_CYC   = T_LOCK_OFF_MS * OSC_KHZ;
    localparam int unsigned T_LOCK_DET_MS  = 400;
    localparam int unsigned LOCK_DET_CYC   = T_LOCK_DET_MS * OSC_KHZ;
    localparam int unsigned T_START_OFF_MS = 1;
    localparam int unsigned START_OFF_CYC  = T_START_OFF_MS * OSC_KHZ;
    localparam int unsigned SPEED_HZ       = 5;
    localparam int unsigned SPEED_EDGE_CYC = OSC_HZ / (2 * SPEED_HZ);
    localparam int unsigned LEAD_MAX_STEP  = 16;
    localparam int unsigned LEAD_SHIFT     = 7;
    localparam int unsigned CODE_W         = 7;
    localparam int unsigned LEAD_W         = 5;
    localparam int unsigned CNT_W          = 9;
    localparam int unsigned TMR_W          = 26;
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [7:0]  ADDR_PERIOD    = 8'h08;
    localparam int unsigned CTRL_EN_BIT    = 0;
    localparam int unsigned CTRL_STOP_LSB  = 8;
    localparam logic        CTRL_EN_RESET  = 1'b1;
    localparam logic [6:0]  STOP_RESET     = 7'h0E;
    localparam int unsigned ST_LOCK_LSB    = 0;
    localparam int unsigned ST_FAST_BIT    = 2;
    localparam int unsigned ST_OCP_BIT     = 3;
    localparam int unsigned ST_TSD_BIT     = 4;
    localparam int unsigned ST_CLIM_BIT    = 5;
    localparam int unsigned ST_FGPIN_BIT   = 6;
    localparam int unsigned ST_LKPIN_BIT   = 7;
    localparam int unsigned ST_DUTY_LSB    = 8;

    typedef enum logic [1:0] {LK_RUN, LK_OFF, LK_ON} sfdc_lock_t;
endpackage

// File: hw/sfdc_sync.sv
// Two-stage synchroniser for a bundle of asynchronous inputs.
module sfdc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// File: hw/sfdc_pwm.sv
// PWM period counter and duty comparator stepped by the oscillator tick.
module sfdc_pwm
    import sfdc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             tick,
    input  wire logic [CNT_W-1:0] duty,
    output logic      [CNT_W-1:0] cnt,
    output logic                  start,
    output logic                  on
);
    wire last = (cnt == CNT_W'(PWM_PERIOD - 1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt   <= '0;
            start <= 1'b0;
            on    <= 1'b0;
        end
        else
        begin
            start <= tick && last;
            if (tick)
                cnt <= last ? '0 : cnt + 1'b1;
            on <= (cnt < duty);
        end
    end

    AST_PERIOD_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && last) |=> (cnt == '0) && start)
        else $error("PWM counter did not wrap after 400 oscillator cycles.");
endmodule

// File: hw/sfdc_top.sv
// Fan drive control: commutation, PWM, protection, open-drain flags, APB registers.
//
// Register access over APB and the address map are this design's own decisions.
module sfdc_top #(
    parameter int unsigned OCP_OFF   = sfdc_pkg::OCP_OFF_CYC,
    parameter int unsigned LOCK_ON   = sfdc_pkg::LOCK_ON_CYC,
    parameter int unsigned LOCK_OFF  = sfdc_pkg::LOCK_OFF_CYC,
    parameter int unsigned LOCK_DET  = sfdc_pkg::LOCK_DET_CYC,
    parameter int unsigned START_OFF = sfdc_pkg::START_OFF_CYC,
    parameter int unsigned SPEED_EDGE = sfdc_pkg::SPEED_EDGE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        hall_pos_in,
    input  wire logic        hall_neg_in,
    input  wire logic        current_sense_in,
    input  wire logic        overcurrent_in,
    input  wire logic        thermal_shutdown_in,
    input  wire logic [6:0]  speed_command_in,
    input  wire logic [6:0]  min_duty_in,
    input  wire logic [4:0]  lead_angle_in,
    output logic             motor_out_a_high,
    output logic             motor_out_a_low,
    output logic             motor_out_b_high,
    output logic             motor_out_b_low,
    output logic             rotation_pulse_out,
    output logic             rotation_pulse_out_oe,
    input  wire logic        rotation_pulse_out_in,
    output logic             lock_flag_out,
    output logic             lock_flag_out_oe,
    input  wire logic        lock_flag_out_in
);
    import sfdc_pkg::*;

    if (OSC_DIV < 2 || LOCK_OFF >= 2**TMR_W || LOCK_DET >= 2**TMR_W - 1
        || SPEED_EDGE >= LOCK_DET || OCP_OFF == 0 || LOCK_ON == 0)
        $error("sfdc_top: timing parameters out of range.");

    localparam int unsigned DIV_W = $clog2(OSC_DIV);

    function automatic logic [CNT_W-1:0] duty_of(input logic [CODE_W-1:0] code);
        logic [CODE_W+CNT_W-1:0] prod;
        prod = code * CNT_W'(PWM_PERIOD);
        duty_of = (code == '1) ? CNT_W'(PWM_PERIOD) : prod[CODE_W+CNT_W-1:LEAD_SHIFT];
    endfunction

    function automatic logic [TMR_W-1:0] lead_of(input logic [TMR_W-1:0] per,
                                                 input logic [LEAD_W-1:0] step);
        logic [LEAD_W-1:0]        st;
        logic [TMR_W+LEAD_W-1:0]  prod;
        st = (step > LEAD_W'(LEAD_MAX_STEP)) ? LEAD_W'(LEAD_MAX_STEP) : step;
        prod = per * st;
        lead_of = TMR_W'(prod[TMR_W+LEAD_W-1:LEAD_SHIFT]);
    endfunction

    // Every pin input except reset and the APB bus passes two flip-flops before use.
    logic [25:0] sy;
    sfdc_sync #(.WIDTH(26)) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({lock_flag_out_in, rotation_pulse_out_in, lead_angle_in, min_duty_in,
                 speed_command_in, thermal_shutdown_in, overcurrent_in,
                 current_sense_in, hall_neg_in, hall_pos_in}),
        .q     (sy)
    );
    wire              hp     = sy[0];
    wire              hm     = sy[1];
    wire              cs     = sy[2];
    wire              ovc    = sy[3];
    wire              tsd    = sy[4];
    wire [CODE_W-1:0] spd    = sy[11:5];
    wire [CODE_W-1:0] mind   = sy[18:12];
    wire [LEAD_W-1:0] lead   = sy[23:19];
    wire              fg_pin = sy[24];
    wire              lk_pin = sy[25];

    // Oscillator time base: all intervals below count these ticks.
    logic [DIV_W-1:0] osc_cnt;
    logic             osc_tick;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_cnt  <= '0;
            osc_tick <= 1'b0;
        end
        else
        begin
            osc_tick <= (osc_cnt == DIV_W'(OSC_DIV - 1));
            osc_cnt  <= (osc_cnt == DIV_W'(OSC_DIV - 1)) ? '0 : osc_cnt + 1'b1;
        end
    end

    // Register file and enable decision.
    logic             en;
    logic [6:0]       stop_thr;
    sfdc_lock_t       lk;
    wire              run = en && (spd > stop_thr);

    // Hall polarity: 1 means output B is the modulated one.
    logic             hall_ph;
    logic             ph;
    logic             ph_q;
    logic             predicted;
    logic [TMR_W-1:0] since_edge;
    logic [TMR_W-1:0] period;
    logic [1:0]       edges;
    logic             fast;
    wire hall_b       = hp && !hm;
    wire hall_a       = !hp && hm;
    wire next_hall_ph = hall_b ? 1'b1 : (hall_a ? 1'b0 : hall_ph);
    wire hall_edge    = (next_hall_ph != hall_ph);
    wire [TMR_W-1:0] lead_cyc = lead_of(period, lead);
    wire predict_hit  = fast && !predicted && (lead_cyc != '0)
                        && (since_edge >= period - lead_cyc);
    wire next_fast    = (edges == 2'd2) && (period <= TMR_W'(SPEED_EDGE))
                        && (since_edge <= TMR_W'(SPEED_EDGE));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hall_ph    <= 1'b0;
            since_edge <= '0;
            period     <= '1;
            edges      <= '0;
            fast       <= 1'b0;
        end
        else
        begin
            hall_ph <= next_hall_ph;
            fast    <= next_fast;
            // The first polarity seen after reset or stop is no timing reference.
            if (hall_edge && run)
            begin
                period     <= since_edge;
                since_edge <= '0;
                edges      <= (edges == 2'd2) ? edges : edges + 1'b1;
            end
            else if (!run)
            begin
                since_edge <= '0;
                edges      <= '0;
            end
            else if (osc_tick && since_edge != '1)
                since_edge <= since_edge + 1'b1;
        end
    end

    // Conducting phase: real edges always resync; predicted flips run ahead.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ph        <= 1'b0;
            ph_q      <= 1'b0;
            predicted <= 1'b0;
        end
        else
        begin
            ph_q <= ph;
            if (hall_edge)
            begin
                ph        <= next_hall_ph;
                predicted <= 1'b0;
            end
            else if (predict_hit)
            begin
                ph        <= !hall_ph;
                predicted <= 1'b1;
            end
            else if (!fast)
            begin
                ph        <= hall_ph;
                predicted <= 1'b0;
            end
        end
    end

    // Duty selection.
    wire [CODE_W-1:0] spd_eff = (spd < mind) ? mind : spd;
    wire [CNT_W-1:0]  duty = fast ? duty_of(spd_eff) : CNT_W'(DUTY_START);

    logic [CNT_W-1:0] pwm_cnt;
    logic             pwm_start;
    logic             pwm_on;
    sfdc_pwm u_pwm (
        .clk   (pclk),
        .rst_n (presetn),
        .tick  (osc_tick),
        .duty  (duty),
        .cnt   (pwm_cnt),
        .start (pwm_start),
        .on    (pwm_on)
    );

    // Current limit, over-current, startup gap and lock timers.
    logic             climit;
    logic [CNT_W-1:0] oc_cnt;
    logic [TMR_W-1:0] ocp_cnt;
    logic [TMR_W-1:0] soff_cnt;
    logic [TMR_W-1:0] lk_cnt;
    wire blank_done = (pwm_cnt >= CNT_W'(BLANK_CYC));
    wire ocp_trip   = osc_tick && ovc && (oc_cnt == CNT_W'(OCP_MASK_CYC));
    wire ocp_active = (ocp_cnt != '0);
    wire lk_expire  = osc_tick && (lk_cnt <= TMR_W'(1));
    wire lock_det   = (lk == LK_RUN) && run && !hall_edge
                      && (since_edge >= TMR_W'(LOCK_DET));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            climit   <= 1'b0;
            oc_cnt   <= '0;
            ocp_cnt  <= '0;
            soff_cnt <= '0;
        end
        else
        begin
            if (cs && blank_done && !pwm_start)
                climit <= 1'b1;
            else if (pwm_start)
                climit <= 1'b0;
            if (!ovc)
                oc_cnt <= '0;
            else if (osc_tick && oc_cnt != '1)
                oc_cnt <= oc_cnt + 1'b1;
            if (ocp_trip)
                ocp_cnt <= TMR_W'(OCP_OFF);
            else if (osc_tick && ocp_active)
                ocp_cnt <= ocp_cnt - 1'b1;
            if (!fast && ph != ph_q)
                soff_cnt <= TMR_W'(START_OFF);
            else if (osc_tick && soff_cnt != '0)
                soff_cnt <= soff_cnt - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lk     <= LK_RUN;
            lk_cnt <= '0;
        end
        else
        begin
            case (lk)
                LK_RUN:
                    if (lock_det)
                    begin
                        lk     <= LK_OFF;
                        lk_cnt <= TMR_W'(LOCK_OFF);
                    end
                LK_OFF:
                    if (!run)
                        lk <= LK_RUN;
                    else if (lk_expire)
                    begin
                        lk     <= LK_ON;
                        lk_cnt <= TMR_W'(LOCK_ON);
                    end
                    else if (osc_tick)
                        lk_cnt <= lk_cnt - 1'b1;
                LK_ON:
                    if (!run || hall_edge)
                        lk <= LK_RUN;
                    else if (lk_expire)
                    begin
                        lk     <= LK_OFF;
                        lk_cnt <= TMR_W'(LOCK_OFF);
                    end
                    else if (osc_tick)
                        lk_cnt <= lk_cnt - 1'b1;
                default:
                    lk <= LK_RUN;
            endcase
        end
    end

    // Output stage: all pins come from flip-flops.
    wire drive_ok = run && (lk != LK_OFF) && !ocp_active && !tsd
                    && (soff_cnt == '0) && (fast || ph == ph_q);
    wire mod      = drive_ok && pwm_on && !climit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            motor_out_a_high      <= 1'b0;
            motor_out_a_low       <= 1'b0;
            motor_out_b_high      <= 1'b0;
            motor_out_b_low       <= 1'b0;
            rotation_pulse_out    <= 1'b0;
            rotation_pulse_out_oe <= 1'b0;
            lock_flag_out         <= 1'b0;
            lock_flag_out_oe      <= 1'b0;
        end
        else
        begin
            motor_out_a_high      <= !ph && mod;
            motor_out_a_low       <= ph && drive_ok;
            motor_out_b_high      <= ph && mod;
            motor_out_b_low       <= !ph && drive_ok;
            rotation_pulse_out    <= 1'b0;
            rotation_pulse_out_oe <= !ph;
            lock_flag_out         <= 1'b0;
            lock_flag_out_oe      <= (lk == LK_RUN);
        end
    end

    // APB slave: no wait states, read data latched in the setup cycle.
    logic [31:0] rd_data;
    logic        rd_hit;
    always_comb
    begin
        rd_data = '0;
        rd_hit  = 1'b1;
        if (paddr == ADDR_CTRL)
            rd_data = {17'h0, stop_thr, 7'h0, en};
        else if (paddr == ADDR_STATUS)
            rd_data = {17'h0, spd_eff, lk_pin, fg_pin, climit, tsd,
                       ocp_active, fast, 2'(lk)};
        else if (paddr == ADDR_PERIOD)
            rd_data = {6'h0, period};
        else
            rd_hit = 1'b0;
    end
    wire acc = psel && penable && pready;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= '0;
            en       <= CTRL_EN_RESET;
            stop_thr <= STOP_RESET;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !rd_hit;
            prdata  <= (psel && !penable && !pwrite) ? rd_data : '0;
            if (acc && pwrite && paddr == ADDR_CTRL)
            begin
                en       <= pwdata[CTRL_EN_BIT];
                stop_thr <= pwdata[CTRL_STOP_LSB +: 7];
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_lock_off_done;
        (lk == LK_OFF) && run && lk_expire;
    endsequence
    sequence s_lock_on_loaded;
        (lk == LK_ON) && (lk_cnt == TMR_W'(LOCK_ON));
    endsequence

    AST_SLOW_SQUARE: assert property ((!fast && hall_edge) |=> ph == $past(next_hall_ph))
        else $error("Startup phase does not follow Hall polarity.");
    AST_PREDICT: assert property ((predict_hit && !hall_edge) |=> ph != $past(ph))
        else $error("Predicted commutation did not switch phase.");
    AST_LEAD_EARLY: assert property ((fast && lead_cyc != '0 && since_edge == period - lead_cyc
        && !predicted && !hall_edge) |=> predicted)
        else $error("Lead angle did not advance commutation.");
    AST_PHASE_MAP: assert property (motor_out_a_low |-> !motor_out_a_high && !motor_out_b_low)
        else $error("Both outputs or both switches of one leg are on.");
    AST_FG_PHASE: assert property ((motor_out_a_high |-> rotation_pulse_out_oe)
        and (motor_out_b_high |-> !rotation_pulse_out_oe))
        else $error("Rotation pulse disagrees with the modulated output.");
    AST_CLIMIT_OFF: assert property (climit && !pwm_start |=> !motor_out_a_high
        && !motor_out_b_high)
        else $error("High side stayed on during current limit.");
    AST_CLIMIT_REARM: assert property (pwm_start |=> !climit)
        else $error("Current limit not released at period start.");
    AST_BLANK: assert property ((!climit && !blank_done && !pwm_start) |=> !climit)
        else $error("Current limit accepted inside blanking.");
    AST_OCP: assert property (ocp_trip |=> ocp_cnt == TMR_W'(OCP_OFF) ##1
        (!motor_out_a_high && !motor_out_a_low && !motor_out_b_high && !motor_out_b_low))
        else $error("Over-current did not turn outputs off.");
    AST_LOCK_RETRY: assert property (s_lock_off_done |=> s_lock_on_loaded)
        else $error("Lock off interval did not give way to a drive attempt.");
    AST_LOCK_FLAG: assert property ((lk != LK_RUN) |=> !lock_flag_out_oe)
        else $error("Lock flag pulled low during lock protection.");
    AST_TSD: assert property (tsd |=> !motor_out_a_high && !motor_out_a_low
        && !motor_out_b_high && !motor_out_b_low)
        else $error("Outputs driven during thermal shutdown.");
    AST_STOP: assert property (!run |=> !motor_out_a_high && !motor_out_b_high
        && !motor_out_a_low && !motor_out_b_low)
        else $error("Outputs driven with the speed command at stop.");
    AST_MIN_DUTY: assert property (fast |-> duty >= duty_of(mind))
        else $error("Duty fell below the minimum duty setting.");
    AST_OPEN_DRAIN: assert property (!rotation_pulse_out && !lock_flag_out)
        else $error("Open-drain output drove high.");
    AST_START_DUTY: assert property (!fast |-> duty == CNT_W'(DUTY_START))
        else $error("Startup duty is not half period.");
    AST_START_GAP: assert property ((!fast && ph != ph_q) |=> soff_cnt == TMR_W'(START_OFF)
        ##1 (!motor_out_a_high && !motor_out_b_high))
        else $error("No off gap at startup phase change.");
    AST_LOCK_DET: assert property (lock_det |=> lk == LK_OFF && lk_cnt == TMR_W'(LOCK_OFF))
        else $error("Missing Hall edges did not enter lock protection.");
    AST_TICK_RATE: assert property (osc_tick |=> !osc_tick)
        else $error("Oscillator tick faster than the oscillator rate.");
endmodule

// File: testbench/sfdc_fan_model.sv
// Fan side model: Hall sensor pair and pull-ups on the open-drain flag pins.
module sfdc_fan_model (
    input  wire logic hall_state,
    input  wire logic pulse_oe,
    input  wire logic lock_oe,
    output logic      hall_pos,
    output logic      hall_neg,
    output logic      pulse_pin,
    output logic      lock_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    assign hall_pos  = hall_state;
    assign hall_neg  = ~hall_state;
    assign pulse_pin = pulse_oe ? 1'b0 : 1'b1;
    assign lock_pin  = lock_oe ? 1'b0 : 1'b1;
endmodule

// File: testbench/test_sfdc_top.sv
// Self-checking bench of the fan drive control block.
module test_sfdc_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hall = 1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, ah, al, bh, bl, fg, fg_oe, lk, lk_oe, hp, hn, fg_pin, lk_pin;
    logic cs = 0, oc = 0, tsd = 0;
    logic [6:0] spd = 7'h05, mind = 7'h00;
    logic [4:0] la = 5'h00;
    int n_errors = 0, n_tests = 0;
    wire [31:0] drv = {28'h0, ah, al, bh, bl};
    sfdc_top #(.OCP_OFF(50), .LOCK_OFF(300), .LOCK_DET(1500),
        .START_OFF(20), .SPEED_EDGE(200)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hall_pos_in(hp),
        .hall_neg_in(hn), .current_sense_in(cs), .overcurrent_in(oc),
        .thermal_shutdown_in(tsd), .speed_command_in(spd), .min_duty_in(mind),
        .lead_angle_in(la), .motor_out_a_high(ah), .motor_out_a_low(al),
        .motor_out_b_high(bh), .motor_out_b_low(bl), .rotation_pulse_out(fg),
        .rotation_pulse_out_oe(fg_oe), .rotation_pulse_out_in(fg_pin),
        .lock_flag_out(lk), .lock_flag_out_oe(lk_oe), .lock_flag_out_in(lk_pin));
    sfdc_fan_model fan (.hall_state(hall), .pulse_oe(fg_oe), .lock_oe(lk_oe),
        .hall_pos(hp), .hall_neg(hn), .pulse_pin(fg_pin), .lock_pin(lk_pin));
    initial
    begin
        forever #25 pclk = ~pclk;
    end
    task final_report;
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic ex);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, x);
        chk({31'h0, e}, {31'h0, ex});
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task duty(input logic [31:0] exp);
        logic [31:0] c;
        c = 0;
        repeat (800) @(negedge pclk) c += {31'h0, ah | bh};
        chk(c, exp);
    endtask
    initial
    begin
        #1_000_000;
        n_errors++;
        final_report;
    end
    initial
    begin
        wait_cyc(6);
        presetn <= 1'b1;
        rd(8'h00, 32'hFFFFFFFF, 32'h00000E01, 1'b0);
        rd(8'h08, 32'hFFFFFFFF, 32'h03FFFFFF, 1'b0);
        rd(8'h0C, 32'hFFFFFFFF, 32'h00000000, 1'b1);
        wait_cyc(20);
        chk(drv, 32'h0);
        chk({31'h0, lk_pin}, 32'h0);
        spd <= 7'h40;
        wr(8'h00, 32'h00005001);
        wait_cyc(20);
        chk(drv, 32'h0);
        wr(8'h00, 32'h00000E01);
        wait_cyc(100);
        chk(drv & 32'hD, 32'h4);
        chk({31'h0, fg_pin}, 32'h1);
        duty(32'd400);
        hall <= 1'b0;
        wait_cyc(10);
        chk(drv, 32'h0);
        wait_cyc(60);
        chk(drv & 32'h7, 32'h1);
        chk({31'h0, fg_pin}, 32'h0);
        duty(32'd400);
        tsd <= 1'b1;
        wait_cyc(10);
        chk(drv, 32'h0);
        tsd <= 1'b0;
        wait_cyc(10);
        chk(drv & 32'h1, 32'h1);
        oc <= 1'b1;
        wait_cyc(30);
        chk(drv & 32'h1, 32'h1);
        wait_cyc(30);
        oc <= 1'b0;
        wait_cyc(5);
        chk(drv, 32'h0);
        rd(8'h04, 32'h8, 32'h8, 1'b0);
        wait_cyc(150);
        chk(drv & 32'h1, 32'h1);
        mind <= 7'h50;
        la   <= 5'h10;
        repeat (5)
        begin
            wait_cyc(300);
            hall <= ~hall;
        end
        wait_cyc(300);
        chk(drv & 32'h5, 32'h1);
        hall <= ~hall;
        rd(8'h04, 32'h7F04, 32'h5004, 1'b0);
        wait_cyc(3300);
        chk(drv, 32'h0);
        chk({31'h0, lk_pin}, 32'h1);
        rd(8'h04, 32'h83, 32'h81, 1'b0);
        wait_cyc(400);
        rd(8'h04, 32'h3, 32'h2, 1'b0);
        chk(drv & 32'h1, 32'h1);
        cs <= 1'b1;
        wait_cyc(800);
        duty(32'd30);
        cs <= 1'b0;
        hall <= ~hall;
        wait_cyc(10);
        rd(8'h04, 32'h3, 32'h0, 1'b0);
        chk({31'h0, lk_pin}, 32'h0);
        final_report;
    end
endmodule
